// ### hw/smis_flag_bank.sv
// smis_flag_bank: one sticky flag per interrupt source, set on a rising
// status bit and cleared by a write-one mask.
// assumes status bits are synchronous to clk_i.
`timescale 1ns/1ps
module smis_flag_bank
    import smis_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [NUM_IRQ-1:0] status_i,
    input wire logic clear_valid_i,
    input wire logic [NUM_IRQ-1:0] clear_mask_i,
    output logic [NUM_IRQ-1:0] flags_o
);

    logic [NUM_IRQ-1:0] status_prev_ff;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            status_prev_ff <= '0;
        end
        else
        begin
            status_prev_ff <= status_i;
        end
    end

    genvar k;
    generate
        for (k = 0; k < NUM_IRQ; k++)
        begin : g_flag
            logic flag_ff;
            logic nxt_flag;
            always_comb
            begin
                nxt_flag = flag_ff;
                if (clear_valid_i && clear_mask_i[k])
                begin
                    nxt_flag = 1'b0; // RULE22
                end
                // a new rising edge wins over a clear in the same cycle
                if (status_i[k] && !status_prev_ff[k])
                begin
                    nxt_flag = 1'b1; // RULE9
                end
            end
            always_ff @(posedge clk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                begin
                    flag_ff <= 1'b0;
                end
                else
                begin
                    flag_ff <= nxt_flag;
                end
            end
            assign flags_o[k] = flag_ff;
        end
    endgenerate

endmodule : smis_flag_bank

// ### hw/smis_pkg.sv
// smis_pkg: register map, field layout, reset values and timing constants
// for the supply monitor, interrupt and sync control block.
// assumes a 25 MHz bus clock and a slow 1 kHz prescaler input.
package smis_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_IRQ = 12;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h00;
    localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h04;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h08;
    localparam logic [7:0] OFS_POWER_CLOCK_STATUS = 8'h0c;
    localparam logic [7:0] OFS_LOOP_CTRL = 8'h24;
    localparam logic [7:0] OFS_LOOP_VALUE = 8'h28;
    localparam logic [7:0] OFS_LOOP_READ_SYNC = 8'h30;
    localparam logic [7:0] OFS_BROWNOUT_MONITOR = 8'h34;
    localparam logic [7:0] OFS_VOLTAGE_REF = 8'h40;

    // status / flag bit positions
    localparam int IRQ_LOOP_READY = 4;
    localparam int IRQ_MONITOR_READY = 9;
    localparam int IRQ_BROWNOUT_DETECTED = 10;
    localparam int IRQ_MONITOR_SYNC_READY = 11;

    // brownout monitor register fields
    localparam int BOD_ENABLE_BIT = 1;
    localparam int BOD_HYSTERESIS_ENABLE_BIT = 2;
    localparam int BOD_ACTION_LSB = 3;
    localparam int BOD_RUN_STANDBY_BIT = 6;
    localparam int BOD_MODE_BIT = 8;
    localparam int BOD_CEN_BIT = 9;
    localparam int BOD_PSEL_LSB = 12;
    localparam int BOD_LEVEL_LSB = 16;
    localparam logic [31:0] BOD_WRITE_MASK = 32'h003f_f35e;

    // loop control register fields
    localparam int LOOP_ENABLE_BIT = 1;
    localparam logic [15:0] LOOP_CTRL_RESET = 16'h0000;
    localparam int READ_REQUEST_BIT = 0;

    // voltage reference register fields
    localparam int TEMP_SENSOR_EN_BIT = 1;
    localparam int BANDGAP_OUT_EN_BIT = 2;
    localparam int BANDGAP_TRIM_LSB = 16;
    localparam int BANDGAP_TRIM_W = 11;

    typedef enum logic [1:0] {
        SMIS_ACT_NONE = 2'h0,
        SMIS_ACT_RESET = 2'h1,
        SMIS_ACT_INTERRUPT = 2'h2
    } smis_action_t;

    // sampled-mode check window
    localparam int CLK_PERIOD_NS = 40;
    localparam int SAMPLE_WINDOW_NS = 320;
    localparam int SAMPLE_WINDOW_CYCLES =
        (SAMPLE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRESCALER_IN_HZ = 1000;

endpackage : smis_pkg

// ### hw/smis_top.sv
// smis_top: brownout monitor control, voltage reference bits, interrupt
// flags and the loop / monitor register synchronisers.
// assumes a plain register port and synchronous status inputs.
//
// Summary of operation
// RULE1: compare supply, raise reset or interrupt
// RULE2: detection result readable in status register
// RULE3: monitor fields loaded from user row
// RULE4: mode clear means continuous monitoring, default
// RULE5: mode set means sampled checks per tick
// RULE6: tick rate is 1kHz over two^(psel+1)
// RULE7: software stops sample clock before prescale change
// RULE8: hysteresis bit adds hysteresis in both modes
// RULE9: flag set on rising status bit
// RULE10: enable set and clear, zeros ignored
// RULE11: request while flag and enable both set
// RULE12: all enabled requests ORed into one
// RULE13: detection wake path needs no clock
// RULE14: loop control writes dropped while not ready
// RULE15: loop read without request starts sync
// RULE16: disabled loop reads never wait
// RULE17: monitor write clears sync ready until done
// RULE18: access during sync completes after sync
// RULE19: software polls, interrupts or just issues access
// RULE20: bandgap trim loaded at reset, write overrides
// RULE21: sensor enable and bandgap output routing
// RULE22: write one clears flag, rise wins
`timescale 1ns/1ps
module smis_top
    import smis_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DATA_W-1:0] RDATA_O,
    input wire logic [3:0] OSC_READY_I,
    input wire logic [4:0] LOOP_STATUS_I,
    input wire logic [31:0] LOOP_VALUE_I,
    output logic [15:0] LOOP_CTRL_O,
    output logic LOOP_READ_SYNC_O,
    input wire logic PRESCALER_CLK_I,
    input wire logic BOD_COMPARE_I,
    input wire logic MONITOR_READY_I,
    input wire logic [31:0] USER_ROW_BOD_I,
    input wire logic [BANDGAP_TRIM_W-1:0] FACTORY_TRIM_I,
    output logic BOD_ANALOG_ON_O,
    output logic BOD_HYSTERESIS_ENABLE_O,
    output logic [5:0] BOD_LEVEL_O,
    output logic BOD_RESET_O,
    output logic BOD_WAKE_O,
    output logic TEMP_SENSOR_EN_O,
    output logic BANDGAP_OUT_EN_O,
    output logic [BANDGAP_TRIM_W-1:0] BANDGAP_TRIM_O,
    output logic IRQ_O
);

    logic wr_enclr, wr_enset, wr_flags, wr_loop, wr_sync, wr_bod, wr_vref;
    logic rd_loop;
    logic load_pend_ff;
    logic [NUM_IRQ-1:0] status, flags, irq_en_ff;
    logic loop_ready, loop_enabled;
    logic [15:0] loop_ctrl_ff;
    logic read_armed_ff, sync_pulse_ff;
    logic [31:0] bod_ctrl_ff, bod_act_ff, pend_data_ff;
    logic busy_ff, pend_valid_ff;
    logic [31:0] nxt_bod_ctrl, nxt_pend_data;
    logic nxt_busy, nxt_pend_valid;
    logic psc_meta_ff, psc_sync_ff, psc_prev_ff, psc_tick;
    logic [15:0] psc_cnt_ff, div_last;
    logic [16:0] div_span;
    logic samp_tick;
    logic [7:0] win_cnt_ff;
    logic det_ff;
    logic act_enable, act_mode, act_cen, monitor_on;
    logic [3:0] act_psel;
    smis_action_t act_action;
    logic [31:0] vref_ff;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;

    assign wr_enclr = WR_I && ADDR_I == OFS_IRQ_ENABLE_CLEAR;
    assign wr_enset = WR_I && ADDR_I == OFS_IRQ_ENABLE_SET;
    assign wr_flags = WR_I && ADDR_I == OFS_IRQ_FLAGS;
    assign wr_loop = WR_I && ADDR_I == OFS_LOOP_CTRL && !load_pend_ff;
    assign wr_sync = WR_I && ADDR_I == OFS_LOOP_READ_SYNC;
    assign wr_bod = WR_I && ADDR_I == OFS_BROWNOUT_MONITOR && !load_pend_ff;
    assign wr_vref = WR_I && ADDR_I == OFS_VOLTAGE_REF && !load_pend_ff;
    assign rd_loop = RD_I && (ADDR_I == OFS_LOOP_CTRL || ADDR_I == OFS_LOOP_VALUE);

    // nonvolatile values are caught on the first edge after reset release
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            load_pend_ff <= 1'b1;
        end
        else
        begin
            load_pend_ff <= 1'b0;
        end
    end

    assign status = {~busy_ff, det_ff, MONITOR_READY_I, LOOP_STATUS_I, OSC_READY_I};

    smis_flag_bank u_flags (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .status_i(status),
        .clear_valid_i(wr_flags),
        .clear_mask_i(WDATA_I[NUM_IRQ-1:0]),
        .flags_o(flags)
    );

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            irq_en_ff <= '0;
        end
        else if (wr_enset)
        begin
            irq_en_ff <= irq_en_ff | WDATA_I[NUM_IRQ-1:0]; // RULE10
        end
        else if (wr_enclr)
        begin
            irq_en_ff <= irq_en_ff & ~WDATA_I[NUM_IRQ-1:0]; // RULE10
        end
    end

    assign IRQ_O = |(flags & irq_en_ff); // RULE11 RULE12

    // locked-loop control: writes only land while the loop reports ready
    assign loop_ready = LOOP_STATUS_I[0];
    assign loop_enabled = loop_ctrl_ff[LOOP_ENABLE_BIT];

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            loop_ctrl_ff <= LOOP_CTRL_RESET;
        end
        else if (wr_loop && loop_ready)
        begin
            loop_ctrl_ff <= WDATA_I[15:0]; // RULE14
        end
    end

    assign LOOP_CTRL_O = loop_ctrl_ff;

    // the port cannot stall, so an unrequested read returns the current
    // value and, while the loop is enabled, kicks off a sync for the next read
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            read_armed_ff <= 1'b0;
            sync_pulse_ff <= 1'b0;
        end
        else
        begin
            sync_pulse_ff <= 1'b0;
            if (wr_sync && WDATA_I[READ_REQUEST_BIT])
            begin
                read_armed_ff <= 1'b1;
                sync_pulse_ff <= 1'b1; // RULE15
            end
            else if (rd_loop && loop_enabled)
            begin
                read_armed_ff <= 1'b0;
                sync_pulse_ff <= !read_armed_ff; // RULE15 RULE16
            end
        end
    end

    assign LOOP_READ_SYNC_O = sync_pulse_ff;

    // prescaler input sampled into the bus clock
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            psc_meta_ff <= 1'b0;
            psc_sync_ff <= 1'b0;
            psc_prev_ff <= 1'b0;
        end
        else
        begin
            psc_meta_ff <= PRESCALER_CLK_I;
            psc_sync_ff <= psc_meta_ff;
            psc_prev_ff <= psc_sync_ff;
        end
    end

    assign psc_tick = psc_sync_ff && !psc_prev_ff;

    // monitor write sync: a queued write completes after the running one
    always_comb
    begin
        nxt_bod_ctrl = bod_ctrl_ff;
        nxt_busy = busy_ff;
        nxt_pend_valid = pend_valid_ff;
        nxt_pend_data = pend_data_ff;
        if (psc_tick && busy_ff)
        begin
            if (pend_valid_ff)
            begin
                nxt_bod_ctrl = pend_data_ff; // RULE18
                nxt_pend_valid = 1'b0;
            end
            else
            begin
                nxt_busy = 1'b0; // RULE17
            end
        end
        if (wr_bod)
        begin
            if (nxt_busy)
            begin
                nxt_pend_valid = 1'b1; // RULE18
                nxt_pend_data = WDATA_I & BOD_WRITE_MASK;
            end
            else
            begin
                nxt_bod_ctrl = WDATA_I & BOD_WRITE_MASK;
                nxt_busy = 1'b1; // RULE17
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            bod_ctrl_ff <= '0;
            bod_act_ff <= '0;
            busy_ff <= 1'b0;
            pend_valid_ff <= 1'b0;
            pend_data_ff <= '0;
        end
        else if (load_pend_ff)
        begin
            bod_ctrl_ff <= USER_ROW_BOD_I & BOD_WRITE_MASK; // RULE3
            bod_act_ff <= USER_ROW_BOD_I & BOD_WRITE_MASK; // RULE3
        end
        else
        begin
            bod_ctrl_ff <= nxt_bod_ctrl;
            busy_ff <= nxt_busy;
            pend_valid_ff <= nxt_pend_valid;
            pend_data_ff <= nxt_pend_data;
            if (psc_tick && busy_ff)
            begin
                bod_act_ff <= bod_ctrl_ff; // RULE17
            end
        end
    end

    assign act_enable = bod_act_ff[BOD_ENABLE_BIT];
    assign act_mode = bod_act_ff[BOD_MODE_BIT];
    assign act_cen = bod_act_ff[BOD_CEN_BIT];
    assign act_psel = bod_act_ff[BOD_PSEL_LSB +: 4];
    assign act_action = smis_action_t'(bod_act_ff[BOD_ACTION_LSB +: 2]);

    // sampling divider: last count is 2^(psel+1)-1 prescaler ticks
    // five-bit shift amount so psel of fifteen still spans 2^16 ticks
    assign div_span = 17'h1 << ({1'b0, act_psel} + 5'h1);
    assign div_last = 16'(div_span - 17'h1);
    assign samp_tick = act_cen && psc_tick && psc_cnt_ff == div_last; // RULE6

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            psc_cnt_ff <= '0;
        end
        else if (!act_cen)
        begin
            psc_cnt_ff <= '0;
        end
        else if (psc_tick)
        begin
            psc_cnt_ff <= (psc_cnt_ff == div_last) ? 16'h0 : psc_cnt_ff + 16'h1; // RULE6
        end
    end

    // short check window per sampling tick, off otherwise
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            win_cnt_ff <= '0;
        end
        else if (samp_tick && act_enable && act_mode)
        begin
            win_cnt_ff <= 8'(SAMPLE_WINDOW_CYCLES); // RULE5
        end
        else if (win_cnt_ff != 8'h0)
        begin
            win_cnt_ff <= win_cnt_ff - 8'h1;
        end
    end

    assign monitor_on = act_enable && (!act_mode || win_cnt_ff != 8'h0); // RULE4 RULE5

    // sampled mode holds the last window's verdict until the next one
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            det_ff <= 1'b0;
        end
        else if (!act_enable)
        begin
            det_ff <= 1'b0;
        end
        else if (!act_mode || win_cnt_ff == 8'h1)
        begin
            det_ff <= BOD_COMPARE_I; // RULE1 RULE2
        end
    end

    assign BOD_ANALOG_ON_O = monitor_on;
    assign BOD_HYSTERESIS_ENABLE_O = bod_act_ff[BOD_HYSTERESIS_ENABLE_BIT]; // RULE8
    assign BOD_LEVEL_O = bod_act_ff[BOD_LEVEL_LSB +: 6]; // RULE1
    assign BOD_RESET_O = det_ff && act_action == SMIS_ACT_RESET; // RULE1
    // wake path is pure logic so it works with the bus clock stopped
    assign BOD_WAKE_O = BOD_COMPARE_I && monitor_on
        && act_action == SMIS_ACT_INTERRUPT; // RULE13

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            vref_ff <= '0;
        end
        else if (load_pend_ff)
        begin
            vref_ff[BANDGAP_TRIM_LSB +: BANDGAP_TRIM_W] <= FACTORY_TRIM_I; // RULE20
        end
        else if (wr_vref)
        begin
            vref_ff <= WDATA_I & 32'h07ff_0006; // RULE20 RULE21
        end
    end

    assign TEMP_SENSOR_EN_O = vref_ff[TEMP_SENSOR_EN_BIT]; // RULE21
    assign BANDGAP_OUT_EN_O = vref_ff[BANDGAP_OUT_EN_BIT]; // RULE21
    assign BANDGAP_TRIM_O = vref_ff[BANDGAP_TRIM_LSB +: BANDGAP_TRIM_W];

    always_comb
    begin
        nxt_rdata = '0;
        case (ADDR_I)
            OFS_IRQ_ENABLE_CLEAR, OFS_IRQ_ENABLE_SET: nxt_rdata = 32'(irq_en_ff);
            OFS_IRQ_FLAGS: nxt_rdata = 32'(flags);
            OFS_POWER_CLOCK_STATUS: nxt_rdata = 32'(status); // RULE2
            OFS_LOOP_CTRL: nxt_rdata = 32'(loop_ctrl_ff);
            OFS_LOOP_VALUE: nxt_rdata = LOOP_VALUE_I;
            OFS_BROWNOUT_MONITOR: nxt_rdata = pend_valid_ff ? pend_data_ff : bod_ctrl_ff; // RULE18
            OFS_VOLTAGE_REF: nxt_rdata = vref_ff;
            default: nxt_rdata = '0;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= RD_I ? nxt_rdata : '0;
        end
    end

    assign RDATA_O = rdata_ff;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    sequence s_bod_write_idle;
        wr_bod && !busy_ff;
    endsequence

    sequence s_sync_finish;
        psc_tick && busy_ff && !pend_valid_ff && !wr_bod;
    endsequence

    flag_on_rise_a: assert property ($rose(det_ff) |=> flags[IRQ_BROWNOUT_DETECTED]) // RULE9
        else $error("detection flag not set after rise");
    flag_clear_a: assert property (wr_flags && WDATA_I[0] && !$rose(OSC_READY_I[0])
        |=> !flags[0]) // RULE22
        else $error("flag not cleared by write one");
    irq_hold_a: assert property (IRQ_O && !wr_flags && !wr_enclr |=> IRQ_O) // RULE11
        else $error("combined request dropped while flag and enable held");
    enable_set_a: assert property (wr_enset && WDATA_I[2] |=> irq_en_ff[2] // RULE10
        ##0 IRQ_O == |(flags & irq_en_ff))
        else $error("enable set lost");
    sync_start_a: assert property (s_bod_write_idle |=> !status[IRQ_MONITOR_SYNC_READY]) // RULE17
        else $error("sync ready not cleared on write");
    sync_done_a: assert property (s_sync_finish |=> status[IRQ_MONITOR_SYNC_READY]
        && bod_act_ff == $past(bod_ctrl_ff)) // RULE17
        else $error("sync did not complete on tick");
    loop_drop_a: assert property (wr_loop && !loop_ready |=> $stable(loop_ctrl_ff)) // RULE14
        else $error("loop write taken while not ready");
    wake_async_a: assert property (BOD_COMPARE_I && monitor_on
        && act_action == SMIS_ACT_INTERRUPT |-> BOD_WAKE_O) // RULE13
        else $error("wake path missing");
    cont_mode_a: assert property (act_enable && !act_mode |-> BOD_ANALOG_ON_O // RULE4
        ##1 det_ff == $past(BOD_COMPARE_I) || !act_enable)
        else $error("continuous monitor not tracking");
    trim_write_a: assert property (wr_vref |=> BANDGAP_TRIM_O == $past(WDATA_I[26:16])) // RULE20
        else $error("trim write lost");

endmodule : smis_top

// ### verif/supply_monitor_irq_sync_tb.sv
// supply_monitor_irq_sync_tb: directed bench for smis_top.
// assumes the bench drives every port itself, with hand-pulsed prescaler ticks.
`timescale 1ns/1ps
module supply_monitor_irq_sync_tb
    import smis_pkg::*;
;
    localparam logic [31:0] ROW = 32'h8012_0016;
    localparam logic [10:0] TRIM = 11'h2a5;
    localparam logic [31:0] LVAL = 32'h1234_abcd;
    logic clk, rst_n, wr_stb, rd_stb, pclk, cmp, sync_seen, counting;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, r;
    logic [9:0] src;
    logic [15:0] loop_ctrl;
    logic loop_sync, ana_on, hysteresis_enable, bod_rst, wake, temp_sensor_enable, bgen, irq;
    logic [5:0] level;
    logic [10:0] trim_o;
    int mismatches, n_compared, on_cnt;

    smis_top dut (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr_stb), .RD_I(rd_stb), .RDATA_O(rdata), .OSC_READY_I(src[3:0]),
        .LOOP_STATUS_I(src[8:4]), .LOOP_VALUE_I(LVAL), .LOOP_CTRL_O(loop_ctrl),
        .LOOP_READ_SYNC_O(loop_sync), .PRESCALER_CLK_I(pclk), .BOD_COMPARE_I(cmp),
        .MONITOR_READY_I(src[9]), .USER_ROW_BOD_I(ROW), .FACTORY_TRIM_I(TRIM),
        .BOD_ANALOG_ON_O(ana_on), .BOD_HYSTERESIS_ENABLE_O(hysteresis_enable), .BOD_LEVEL_O(level),
        .BOD_RESET_O(bod_rst), .BOD_WAKE_O(wake), .TEMP_SENSOR_EN_O(temp_sensor_enable),
        .BANDGAP_OUT_EN_O(bgen), .BANDGAP_TRIM_O(trim_o), .IRQ_O(irq));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // window cycles are counted here so the sampled scenario can tick freely
    always @(posedge clk)
    begin
        if (counting && ana_on === 1'b1)
            on_cnt++;
    end

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
        sync_seen = loop_sync;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
        sync_seen = loop_sync;
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic tick();
        @(posedge clk);
        pclk <= 1'b1;
        repeat (8) @(posedge clk);
        pclk <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : tick

    task automatic bod_write(input logic [31:0] v);
        logic [31:0] s;
        wr(OFS_BROWNOUT_MONITOR, v);
        rd(OFS_POWER_CLOCK_STATUS, s);
        chk(32'(s[IRQ_MONITOR_SYNC_READY]), 32'h0);
        tick();
        rd(OFS_POWER_CLOCK_STATUS, s);
        chk(32'(s[IRQ_MONITOR_SYNC_READY]), 32'h1);
    endtask : bod_write

    task automatic t_reset_values();
        rd(OFS_BROWNOUT_MONITOR, r);
        chk(r, ROW & BOD_WRITE_MASK);
        chk(32'(level), 32'h12);
        chk(32'(hysteresis_enable), 32'h1);
        chk(32'(ana_on), 32'h1);
        rd(OFS_VOLTAGE_REF, r);
        chk(32'(r[26:16]), 32'(TRIM));
        chk(32'(trim_o), 32'(TRIM));
    endtask : t_reset_values

    task automatic t_detect();
        @(posedge clk);
        cmp <= 1'b1;
        #1;
        chk(32'(wake), 32'h1);
        wait_cyc(3);
        rd(OFS_POWER_CLOCK_STATUS, r);
        chk(32'(r[IRQ_BROWNOUT_DETECTED]), 32'h1);
        chk(32'(bod_rst), 32'h0);
        rd(OFS_IRQ_FLAGS, r);
        chk(32'(r[IRQ_BROWNOUT_DETECTED]), 32'h1);
        @(posedge clk);
        cmp <= 1'b0;
        wait_cyc(3);
    endtask : t_detect

    task automatic t_irq();
        wr(OFS_IRQ_FLAGS, 32'h0000_0fff);
        wr(OFS_IRQ_ENABLE_SET, 32'h0000_0005);
        wr(OFS_IRQ_ENABLE_SET, 32'h0);
        rd(OFS_IRQ_ENABLE_CLEAR, r);
        chk(r, 32'h0000_0005);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h0000_0004);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h0);
        rd(OFS_IRQ_ENABLE_CLEAR, r);
        chk(r, 32'h0000_0001);
        chk(32'(irq), 32'h0);
        @(posedge clk);
        src[1] <= 1'b1;
        wait_cyc(3);
        chk(32'(irq), 32'h0);
        @(posedge clk);
        src[0] <= 1'b1;
        wait_cyc(3);
        chk(32'(irq), 32'h1);
        wr(OFS_IRQ_FLAGS, 32'h0000_0002);
        rd(OFS_IRQ_FLAGS, r);
        chk(32'(r[11:0]), 32'h1);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h0000_0001);
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_ENABLE_SET, 32'h0000_0001);
        chk(32'(irq), 32'h1);
        wr(OFS_IRQ_FLAGS, 32'h0000_0001);
        chk(32'(irq), 32'h0);
    endtask : t_irq

    task automatic t_src_flags();
        @(posedge clk);
        src <= 10'h0;
        wait_cyc(2);
        for (int i = 0; i < 10; i++)
        begin
            wr(OFS_IRQ_FLAGS, 32'h0000_0fff);
            @(posedge clk);
            src[i] <= 1'b1;
            wait_cyc(3);
            rd(OFS_IRQ_FLAGS, r);
            chk(32'(r[11:0]), 32'h1 << i);
            rd(OFS_POWER_CLOCK_STATUS, r);
            chk(32'(r[9:0]), (32'h2 << i) - 32'h1);
        end
    endtask : t_src_flags

    task automatic t_loop();
        @(posedge clk);
        src[4] <= 1'b0;
        wait_cyc(2);
        wr(OFS_LOOP_CTRL, 32'h0000_0002);
        chk(32'(loop_ctrl), 32'h0);
        @(posedge clk);
        src[4] <= 1'b1;
        wait_cyc(2);
        wr(OFS_LOOP_CTRL, 32'h0000_0002);
        chk(32'(loop_ctrl), 32'h2);
        rd(OFS_LOOP_VALUE, r);
        chk(r, LVAL);
        chk(32'(sync_seen), 32'h1);
        wr(OFS_LOOP_READ_SYNC, 32'h0000_0001);
        chk(32'(sync_seen), 32'h1);
        wr(OFS_LOOP_CTRL, 32'h0);
        rd(OFS_LOOP_VALUE, r);
        chk(r, LVAL);
        chk(32'(sync_seen), 32'h0);
    endtask : t_loop

    task automatic t_vref();
        wr(OFS_VOLTAGE_REF, 32'h015a_0006);
        chk(32'(temp_sensor_enable), 32'h1);
        chk(32'(bgen), 32'h1);
        chk(32'(trim_o), 32'h15a);
        wr(OFS_VOLTAGE_REF, 32'h015a_0000);
        chk(32'({temp_sensor_enable, bgen}), 32'h0);
    endtask : t_vref

    // second write lands while the first sync is still open
    task automatic t_bod_sync();
        wr(OFS_BROWNOUT_MONITOR, 32'h0005_000a);
        rd(OFS_POWER_CLOCK_STATUS, r);
        chk(32'(r[IRQ_MONITOR_SYNC_READY]), 32'h0);
        wr(OFS_BROWNOUT_MONITOR, 32'h0007_000a);
        rd(OFS_BROWNOUT_MONITOR, r);
        chk(r, 32'h0007_000a);
        chk(32'(level), 32'h12);
        tick();
        tick();
        rd(OFS_POWER_CLOCK_STATUS, r);
        chk(32'(r[IRQ_MONITOR_SYNC_READY]), 32'h1);
        chk(32'(level), 32'h7);
        chk(32'(hysteresis_enable), 32'h0);
        rd(OFS_IRQ_FLAGS, r);
        chk(32'(r[IRQ_MONITOR_SYNC_READY]), 32'h1);
        @(posedge clk);
        cmp <= 1'b1;
        wait_cyc(3);
        chk(32'(bod_rst), 32'h1);
        @(posedge clk);
        cmp <= 1'b0;
        wait_cyc(3);
        chk(32'(bod_rst), 32'h0);
    endtask : t_bod_sync

    task automatic t_sampled();
        for (int p = 0; p < 2; p++)
        begin
            bod_write(32'h0000_0112);
            bod_write(32'h0000_0312 | (32'(p) << BOD_PSEL_LSB));
            on_cnt = 0;
            counting = 1'b1;
            repeat (4) tick();
            wait_cyc(16);
            counting = 1'b0;
            chk(32'(on_cnt), 32'd16 >> p);
        end
    endtask : t_sampled

    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    initial
    begin
        rst_n = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        pclk = 1'b0;
        cmp = 1'b0;
        counting = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        src = 10'h0;
        mismatches = 0;
        n_compared = 0;
        on_cnt = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_detect();
        t_irq();
        t_src_flags();
        t_loop();
        t_vref();
        t_bod_sync();
        t_sampled();
        complete_run();
    end
endmodule : supply_monitor_irq_sync_tb
